// *** pkg/emb_pkg.sv ***
/*
  Constants shared by the dual-port embedded memory block and its port front end.
  Assumes a single 10 MHz reference clock that samples every port pin.
*/
package emb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NUM_PORTS     = 2;
  localparam int unsigned PORT_A        = 0;
  localparam int unsigned PORT_B        = 1;
  localparam int unsigned DEPTH         = 512;
  localparam int unsigned TOTAL_BITS    = 4608;
  localparam int unsigned NARROW_W      = 9;
  localparam int unsigned WIDE_W        = 18;
  localparam int unsigned ADDR_W        = 9;
  localparam int unsigned CASC_W        = 2;
  localparam int unsigned SYNC_W        = 34;
  localparam logic [8:0]  ROM_SEED      = 9'h0A5;
  localparam logic [17:0] DATA_RST      = 18'h00000;
  localparam logic        HALF_LO       = 1'b0;
  localparam logic        HALF_HI       = 1'b1;
  typedef logic [ADDR_W-1:0] emb_addr_t;
  typedef logic [WIDE_W-1:0] emb_word_t;
endpackage

// *** logic/emb_port.sv ***
/*
  One port front end of the embedded memory block: synchronises the port pins,
  finds the active edge of the port clock and turns it into read and write pulses.
  Assumes the port pins come from fabric logic outside the reference clock domain.
*/
module emb_port (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          pclk_i,
  input  wire logic                          clk_fall_i,
  input  wire logic                          ce_n_i,
  input  wire logic                          we_i,
  input  wire logic                          oe_i,
  input  wire logic [emb_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [emb_pkg::CASC_W-1:0]    casc_i,
  input  wire logic [emb_pkg::WIDE_W-1:0]    din_i,
  output      logic                          edge_o,
  output      logic                          wr_o,
  output      logic                          rd_o,
  output      logic                          oe_o,
  output      emb_pkg::emb_addr_t            addr_o,
  output      logic [emb_pkg::CASC_W-1:0]    casc_o,
  output      emb_pkg::emb_word_t            din_o
);
  logic [emb_pkg::SYNC_W-1:0] meta_reg;
  logic [emb_pkg::SYNC_W-1:0] meta_next;
  logic [emb_pkg::SYNC_W-1:0] sync_reg;
  logic [emb_pkg::SYNC_W-1:0] sync_next;
  logic                       clk_prev_reg;
  logic                       clk_prev_next;
  logic                       s_clk;
  logic                       s_fall;
  logic                       s_ce_n;
  logic                       s_we;

  // Two-stage pin synchroniser
  always_comb begin
    meta_next     = {pclk_i, clk_fall_i, ce_n_i, we_i, oe_i, addr_i, casc_i, din_i};
    sync_next     = meta_reg;
    clk_prev_next = s_clk;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg     <= '0;
      sync_reg     <= '0;
      clk_prev_reg <= 1'b0;
    end else begin
      meta_reg     <= meta_next;
      sync_reg     <= sync_next;
      clk_prev_reg <= clk_prev_next;
    end
  end

  always_comb begin
    {s_clk, s_fall, s_ce_n, s_we, oe_o, addr_o, casc_o, din_o} = sync_reg;
    edge_o = s_fall ? (clk_prev_reg & ~s_clk) : (~clk_prev_reg & s_clk);
    wr_o   = edge_o & ~s_ce_n & s_we;
    rd_o   = edge_o & ~s_ce_n & ~s_we;
  end
endmodule

// *** logic/emb_ram.sv ***
/*
  Dual-port embedded memory block: 4608 bits, 512x9 or 256x18, RAM or preset ROM,
  synchronous or asynchronous read, cascadable by a block select on the column lines.
  Assumes all pins are sampled by ref_clk_i, which must run well above the port clocks.
*/
module emb_ram (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        cfg_wide_i,
  input  wire logic                        cfg_rom_i,
  input  wire logic                        cfg_async_i,
  input  wire logic                        cfg_cascade_i,
  input  wire logic [emb_pkg::CASC_W-1:0]  cfg_blk_id_i,
  input  wire logic                        a_clk_i,
  input  wire logic                        a_clk_fall_i,
  input  wire logic                        a_ce_n_i,
  input  wire logic                        a_we_i,
  input  wire logic                        a_oe_i,
  input  wire logic [emb_pkg::ADDR_W-1:0]  a_addr_i,
  input  wire logic [emb_pkg::CASC_W-1:0]  a_casc_i,
  input  wire logic [emb_pkg::WIDE_W-1:0]  a_data_i,
  output      logic [emb_pkg::WIDE_W-1:0]  a_data_o,
  output      logic                        a_data_oe_o,
  input  wire logic                        b_clk_i,
  input  wire logic                        b_clk_fall_i,
  input  wire logic                        b_ce_n_i,
  input  wire logic                        b_we_i,
  input  wire logic                        b_oe_i,
  input  wire logic [emb_pkg::ADDR_W-1:0]  b_addr_i,
  input  wire logic [emb_pkg::CASC_W-1:0]  b_casc_i,
  input  wire logic [emb_pkg::WIDE_W-1:0]  b_data_i,
  output      logic [emb_pkg::WIDE_W-1:0]  b_data_o,
  output      logic                        b_data_oe_o
);
  localparam int unsigned NP = emb_pkg::NUM_PORTS;

  // Storage, 512 cells of 9 bits; a wide word takes two cells
  logic [emb_pkg::NARROW_W-1:0] mem [emb_pkg::DEPTH];

  logic [4+emb_pkg::CASC_W-1:0] cfg_meta_reg;
  logic [4+emb_pkg::CASC_W-1:0] cfg_sync_reg;
  logic [4+emb_pkg::CASC_W-1:0] cfg_meta_next;
  logic [4+emb_pkg::CASC_W-1:0] cfg_sync_next;
  logic                         wide;
  logic                         rom;
  logic                         async_rd;
  logic                         cascade;
  logic [emb_pkg::CASC_W-1:0]   blk_id;

  logic [NP-1:0]               p_pclk;
  logic [NP-1:0]               p_fall;
  logic [NP-1:0]               p_ce_n;
  logic [NP-1:0]               p_we;
  logic [NP-1:0]               p_oe_in;
  emb_pkg::emb_addr_t          p_addr_in [NP];
  logic [emb_pkg::CASC_W-1:0]  p_casc_in [NP];
  emb_pkg::emb_word_t          p_din_in  [NP];

  logic [NP-1:0]               p_edge;
  logic [NP-1:0]               p_wr;
  logic [NP-1:0]               p_rd;
  logic [NP-1:0]               p_oe;
  emb_pkg::emb_addr_t          p_addr [NP];
  logic [emb_pkg::CASC_W-1:0]  p_casc [NP];
  emb_pkg::emb_word_t          p_din  [NP];

  logic [NP-1:0]               sel;
  logic [NP-1:0]               wr_ok;
  emb_pkg::emb_word_t          rd_word [NP];

  emb_pkg::emb_word_t          hold_reg  [NP];
  emb_pkg::emb_word_t          hold_next [NP];
  emb_pkg::emb_word_t          out_reg   [NP];
  emb_pkg::emb_word_t          out_next  [NP];
  logic [NP-1:0]               oe_reg;
  logic [NP-1:0]               oe_next;

  // Cell index of one half of a word
  function automatic emb_pkg::emb_addr_t cell_idx(input emb_pkg::emb_addr_t a,
                                                  input logic w,
                                                  input logic half);
    cell_idx = w ? {a[emb_pkg::ADDR_W-2:0], half} : a;
  endfunction

  // Preset contents held when used as ROM
  function automatic logic [emb_pkg::NARROW_W-1:0] rom_word(input int unsigned i);
    rom_word = emb_pkg::ROM_SEED ^ i[emb_pkg::NARROW_W-1:0];
  endfunction

  initial begin
    for (int unsigned i = 0; i < emb_pkg::DEPTH; i++) begin
      mem[i] = rom_word(i);
    end
  end

  // Static configuration straps, synchronised
  always_comb begin
    cfg_meta_next = {cfg_wide_i, cfg_rom_i, cfg_async_i, cfg_cascade_i, cfg_blk_id_i};
    cfg_sync_next = cfg_meta_reg;
    {wide, rom, async_rd, cascade, blk_id} = cfg_sync_reg;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_meta_reg <= '0;
      cfg_sync_reg <= '0;
    end else begin
      cfg_meta_reg <= cfg_meta_next;
      cfg_sync_reg <= cfg_sync_next;
    end
  end

  always_comb begin
    p_pclk  = {b_clk_i, a_clk_i};
    p_fall  = {b_clk_fall_i, a_clk_fall_i};
    p_ce_n  = {b_ce_n_i, a_ce_n_i};
    p_we    = {b_we_i, a_we_i};
    p_oe_in = {b_oe_i, a_oe_i};
    p_addr_in[emb_pkg::PORT_A] = a_addr_i;
    p_addr_in[emb_pkg::PORT_B] = b_addr_i;
    p_casc_in[emb_pkg::PORT_A] = a_casc_i;
    p_casc_in[emb_pkg::PORT_B] = b_casc_i;
    p_din_in[emb_pkg::PORT_A]  = a_data_i;
    p_din_in[emb_pkg::PORT_B]  = b_data_i;
  end

  // Two identical independent ports
  for (genvar p = 0; p < NP; p++) begin : g_port
    emb_port u_port (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .pclk_i     (p_pclk[p]),
      .clk_fall_i (p_fall[p]),
      .ce_n_i     (p_ce_n[p]),
      .we_i       (p_we[p]),
      .oe_i       (p_oe_in[p]),
      .addr_i     (p_addr_in[p]),
      .casc_i     (p_casc_in[p]),
      .din_i      (p_din_in[p]),
      .edge_o     (p_edge[p]),
      .wr_o       (p_wr[p]),
      .rd_o       (p_rd[p]),
      .oe_o       (p_oe[p]),
      .addr_o     (p_addr[p]),
      .casc_o     (p_casc[p]),
      .din_o      (p_din[p])
    );
  end

  // Block select, write gating and read mux
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      sel[p]   = ~cascade | (p_casc[p] == blk_id);
      wr_ok[p] = p_wr[p] & sel[p] & ~rom;
      rd_word[p] = {mem[cell_idx(p_addr[p], wide, emb_pkg::HALF_HI)],
                    mem[cell_idx(p_addr[p], wide, emb_pkg::HALF_LO)]};
      if (!wide) begin
        rd_word[p] = {{emb_pkg::NARROW_W{1'b0}},
                      mem[cell_idx(p_addr[p], wide, emb_pkg::HALF_LO)]};
      end
    end
  end

  // Port B written first so port A wins a same-cell clash; parity bits stored as data
  always_ff @(posedge ref_clk_i) begin
    for (int p = NP - 1; p >= 0; p--) begin
      if (wr_ok[p]) begin
        mem[cell_idx(p_addr[p], wide, emb_pkg::HALF_LO)] <=
          p_din[p][emb_pkg::NARROW_W-1:0];
        if (wide) begin
          mem[cell_idx(p_addr[p], wide, emb_pkg::HALF_HI)] <=
            p_din[p][emb_pkg::WIDE_W-1:emb_pkg::NARROW_W];
        end
      end
    end
  end

  // Output word capture and output enable
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      hold_next[p] = hold_reg[p];
      if (async_rd & sel[p]) begin
        hold_next[p] = rd_word[p];
      end else if (p_rd[p] & sel[p]) begin
        hold_next[p] = rd_word[p];
      end
      oe_next[p]  = p_oe[p] & sel[p];
      out_next[p] = oe_next[p] ? hold_next[p] : emb_pkg::DATA_RST;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < NP; p++) begin
        hold_reg[p] <= emb_pkg::DATA_RST;
        out_reg[p]  <= emb_pkg::DATA_RST;
      end
      oe_reg <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        hold_reg[p] <= hold_next[p];
        out_reg[p]  <= out_next[p];
      end
      oe_reg <= oe_next;
    end
  end

  always_comb begin
    a_data_o    = out_reg[emb_pkg::PORT_A];
    a_data_oe_o = oe_reg[emb_pkg::PORT_A];
    b_data_o    = out_reg[emb_pkg::PORT_B];
    b_data_oe_o = oe_reg[emb_pkg::PORT_B];
  end
endmodule

// *** testbench/emb_ram_asserts.sv ***
/*
  Checker for the port outputs of emb_ram.
  Assumes it is bound to emb_ram and sees its ports only.
*/
module emb_ram_asserts (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        cfg_async_i,
  input wire logic        cfg_cascade_i,
  input wire logic [1:0]  cfg_blk_id_i,
  input wire logic        a_ce_n_i,
  input wire logic        a_oe_i,
  input wire logic [1:0]  a_casc_i,
  input wire logic [17:0] a_data_o,
  input wire logic        a_data_oe_o,
  input wire logic        b_ce_n_i,
  input wire logic        b_oe_i,
  input wire logic [17:0] b_data_o,
  input wire logic        b_data_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_a_off;
    !a_oe_i [*4];
  endsequence
  sequence s_b_off;
    !b_oe_i [*4];
  endsequence
  property p_rst;
    $fell(rst_i) |-> !a_data_oe_o && !b_data_oe_o;
  endproperty
  property p_a_off;
    s_a_off |-> !a_data_oe_o;
  endproperty
  property p_b_off;
    s_b_off |-> !b_data_oe_o;
  endproperty
  property p_a_zero;
    !a_data_oe_o |-> a_data_o == 18'h00000;
  endproperty
  property p_b_zero;
    !b_data_oe_o |-> b_data_o == 18'h00000;
  endproperty
  property p_a_ce;
    (a_ce_n_i && a_oe_i && !cfg_async_i && !cfg_cascade_i) [*6] |-> $stable(a_data_o);
  endproperty
  property p_b_ce;
    (b_ce_n_i && b_oe_i && !cfg_async_i && !cfg_cascade_i) [*6] |-> $stable(b_data_o);
  endproperty
  property p_casc;
    (cfg_cascade_i && a_casc_i != cfg_blk_id_i) [*5] |-> !a_data_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("enable after reset");
  a_a_off: assert property (p_a_off) else $error("port a enabled");
  a_b_off: assert property (p_b_off) else $error("port b enabled");
  a_a_zero: assert property (p_a_zero) else $error("port a data");
  a_b_zero: assert property (p_b_zero) else $error("port b data");
  a_a_ce: assert property (p_a_ce) else $error("port a moved");
  a_b_ce: assert property (p_b_ce) else $error("port b moved");
  a_casc: assert property (p_casc) else $error("unselected drives");
endmodule

bind emb_ram emb_ram_asserts emb_ram_asserts_inst (.*);

// *** testbench/emb_fab.sv ***
/*
  Fabric user logic for one port: one access per go pulse, with a port clock pulse.
  Assumes go_i is a one-cycle pulse and comes only while idle.
*/
module emb_fab (
  input  wire logic        ref_clk_i,
  input  wire logic        go_i,
  input  wire logic        we_i,
  input  wire logic        ce_n_i,
  input  wire logic [8:0]  addr_i,
  input  wire logic [15:0] d_i,
  output      logic        pclk_o,
  output      logic        ce_n_o,
  output      logic        we_o,
  output      logic [8:0]  addr_o,
  output      logic [17:0] data_o,
  output      logic        done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial {pclk_o, ce_n_o, we_o, addr_o, data_o, done_o} = {2'b01, 29'h0};
  always @(posedge ref_clk_i) begin
    done_o <= 1'b0;
    if (cnt == 0 && go_i) begin
      {ce_n_o, we_o, addr_o} <= {ce_n_i, we_i, addr_i};
      data_o <= {^d_i[15:8], d_i[15:8], ^d_i[7:0], d_i[7:0]};
      cnt <= 1;
    end else if (cnt != 0) begin
      pclk_o <= cnt >= 3 && cnt < 7;
      cnt <= (cnt == 11) ? 0 : cnt + 1;
      if (cnt == 11) begin
        {ce_n_o, we_o, done_o} <= 3'b101;
        data_o <= ~data_o;
      end
    end
  end
endmodule

// *** testbench/emb_ram_tb.sv ***
/*
  Self-checking bench for emb_ram: random and corner accesses on both ports.
  Assumes emb_pkg, emb_fab and the checker are compiled first.
*/
module emb_ram_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wide = 1'b0, rom = 1'b0, asy = 1'b0, casc = 1'b0;
  logic [1:0]  bid = 2'h0, pcs [2] = '{default: 2'h0};
  logic        go [2] = '{default: 1'b0}, fwe [2] = '{default: 1'b0};
  logic        fce [2] = '{default: 1'b1}, oe [2] = '{default: 1'b0};
  logic        fall [2] = '{default: 1'b0}, pk [2], pce [2], pwe [2], dn [2], qe [2];
  logic [8:0]  fa [2] = '{default: 9'h000}, pad [2], mem [512], a;
  logic [15:0] fd [2] = '{default: 16'h0000}, d;
  logic [17:0] q [2], pdt [2];
  logic [31:0] rs = 32'h4D787660;
  int          bad_count = 0, tests_run = 0, cyc = 0;
  emb_ram emb_ram_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_wide_i(wide), .cfg_rom_i(rom),
    .cfg_async_i(asy), .cfg_cascade_i(casc), .cfg_blk_id_i(bid),
    .a_clk_i(pk[0]), .a_clk_fall_i(fall[0]), .a_ce_n_i(pce[0]), .a_we_i(pwe[0]),
    .a_oe_i(oe[0]), .a_addr_i(pad[0]), .a_casc_i(pcs[0]), .a_data_i(pdt[0]),
    .a_data_o(q[0]), .a_data_oe_o(qe[0]),
    .b_clk_i(pk[1]), .b_clk_fall_i(fall[1]), .b_ce_n_i(pce[1]), .b_we_i(pwe[1]),
    .b_oe_i(oe[1]), .b_addr_i(pad[1]), .b_casc_i(pcs[1]), .b_data_i(pdt[1]),
    .b_data_o(q[1]), .b_data_oe_o(qe[1]));
  for (genvar i = 0; i < 2; i++) begin : g_fab
    emb_fab emb_fab_inst (.ref_clk_i(ref_clk_i), .go_i(go[i]), .we_i(fwe[i]),
      .ce_n_i(fce[i]), .addr_i(fa[i]), .d_i(fd[i]), .pclk_o(pk[i]), .ce_n_o(pce[i]),
      .we_o(pwe[i]), .addr_o(pad[i]), .data_o(pdt[i]), .done_o(dn[i]));
  end
  always #50 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [17:0] expw(input logic [8:0] x);
    if (wide) return {mem[{x[7:0], 1'b1}], mem[{x[7:0], 1'b0}]};
    return {9'h000, mem[x]};
  endfunction
  task automatic chk(input logic [17:0] g, e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_en(input logic g, e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic acc(input int p, input logic w, c, input logic [8:0] x, input logic [15:0] v);
    int n;
    n = 0;
    {fwe[p], fce[p], fa[p], fd[p], go[p]} <= {w, c, x, v, 1'b1};
    @(posedge ref_clk_i);
    go[p] <= 1'b0;
    do @(posedge ref_clk_i); while (dn[p] !== 1'b1 && ++n < 30);
    if (dn[p] !== 1'b1) bad_count++;
    repeat (2) @(posedge ref_clk_i);
    if (w && !c && !rom && (!casc || pcs[p] == bid)) begin
      if (!wide) mem[x] = {^v[7:0], v[7:0]};
      else {mem[{x[7:0], 1'b1}], mem[{x[7:0], 1'b0}]} = {^v[15:8], v[15:8], ^v[7:0], v[7:0]};
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  always @(posedge ref_clk_i) begin
    if (++cyc == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = emb_pkg::ROM_SEED ^ i[8:0];
    step(3);
    rst_i <= 1'b0;
    step(5);
    {oe[0], oe[1], fall[1]} <= 3'b111;
    step(4);
    for (int i = 0; i < 14; i++) begin
      rs = lfsr(rs);
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : rs[8:0];
      d = rs[31:16];
      if (i < 3) acc(0, 0, 0, a, d);
      if (i < 3) chk(q[0], expw(a));
      acc(0, 1, 0, a, d);
      acc(1, 0, 0, a, ~d);
      chk(q[1], expw(a));
    end
    acc(0, 1, 1, a, ~d);
    acc(1, 0, 1, a ^ 9'h001, d);
    chk(q[1], expw(a));
    acc(1, 0, 0, a, ~d);
    chk(q[1], expw(a));
    wide <= 1'b1;
    step(4);
    for (int i = 0; i < 8; i++) begin
      rs = lfsr(rs);
      acc(1, 1, 0, rs[8:0], rs[31:16]);
      acc(0, 0, 0, rs[8:0], 16'h0000);
      chk(q[0], expw(rs[8:0]));
    end
    a = rs[8:0];
    rom <= 1'b1;
    step(4);
    acc(0, 1, 0, a, ~rs[31:16]);
    acc(1, 0, 0, a, 16'h0000);
    chk(q[1], expw(a));
    rom <= 1'b0;
    {oe[0], oe[1]} <= 2'b00;
    step(5);
    chk_en(qe[1], 1'b0);
    chk(q[1], 18'h00000);
    {oe[0], oe[1]} <= 2'b11;
    step(5);
    chk_en(qe[1], 1'b1);
    chk(q[1], expw(a));
    asy <= 1'b1;
    step(4);
    for (int i = 0; i < 4; i++) begin
      rs = lfsr(rs);
      acc(0, 0, 1, rs[8:0], 16'h0000);
      chk(q[0], expw(rs[8:0]));
    end
    asy <= 1'b0;
    {casc, bid, pcs[0]} <= 5'b11001;
    step(6);
    chk_en(qe[0], 1'b0);
    acc(0, 1, 0, a, ~rs[15:0]);
    pcs[0] <= 2'h2;
    step(4);
    acc(0, 0, 0, a, 16'h0000);
    chk(q[0], expw(a));
    rst_i <= 1'b1;
    step(2);
    chk_en(qe[0], 1'b0);
    chk_en(qe[1], 1'b0);
    chk(q[0], 18'h00000);
    rst_i <= 1'b0;
    step(3);
    tally_and_finish;
  end
endmodule
